// >>> dv/ctbr_properties.sv
// concurrent checks on the tie-off/bias register bank ports
// assumes it is bound into ctbr_top and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
`include "ctbr_regs.svh"
module ctbr_properties #(
    parameter int ADR_W = 12,
    parameter int VAL_W = 9
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic [7:0]       auto_tieoff_close_i,
    input wire logic [7:0]       tieoff_close_o,
    input wire logic             input_buffer_enabled_i,
    input wire logic             auto_buffer_bypass_close_i,
    input wire logic             auto_buffer_ground_close_i,
    input wire logic [2:0]       pwr_mgmt_ref_close_i,
    input wire logic             buffer_bypass_close_o,
    input wire logic             buffer_ground_close_o,
    input wire logic [2:0]       ref_divider_close_o,
    input wire logic             boost_bias_half_o,
    input wire logic             boost_bias_increase_o,
    input wire logic             boost_bias_decrease_o,
    input wire logic             alc_left_active_i,
    input wire logic             alc_right_active_i,
    input wire logic [VAL_W-1:0] left_peak_to_peak_i,
    input wire logic [VAL_W-1:0] right_peak_to_peak_i,
    input wire logic [VAL_W-1:0] left_peak_i,
    input wire logic [VAL_W-1:0] right_peak_i
);
    ctbr_pkg::ctbr_word_t tie_ff;
    ctbr_pkg::ctbr_word_t bias_ff;
    logic                 wr_take;
    logic [7:0]           tie_want;
    logic                 byp_want;
    logic                 gnd_want;
    logic [2:0]           ref_want;
    logic [VAL_W-1:0]     p2p_want;
    logic [VAL_W-1:0]     peak_want;
    logic                 one_ch;
    assign wr_take   = cyc_i && stb_i && !ack_o && we_i;
    assign tie_want  = tie_ff[8] ? tie_ff[7:0] : auto_tieoff_close_i;
    assign byp_want  = auto_buffer_bypass_close_i | (bias_ff[4] & ~input_buffer_enabled_i);
    assign gnd_want  = auto_buffer_ground_close_i | (bias_ff[3] & ~input_buffer_enabled_i);
    assign ref_want  = bias_ff[2:0] | pwr_mgmt_ref_close_i;
    // lone channel reports itself; none gives left
    assign one_ch    = alc_right_active_i && !alc_left_active_i;
    assign p2p_want  = (alc_left_active_i && alc_right_active_i) ?
        ((left_peak_to_peak_i > right_peak_to_peak_i) ? left_peak_to_peak_i : right_peak_to_peak_i)
        : (one_ch ? right_peak_to_peak_i : left_peak_to_peak_i);
    assign peak_want = (alc_left_active_i && alc_right_active_i) ?
        ((left_peak_i > right_peak_i) ? left_peak_i : right_peak_i)
        : (one_ch ? right_peak_i : left_peak_i);
    // shadow of the two control words, rebuilt from bus writes only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tie_ff  <= 9'h000;
            bias_ff <= 9'h000;
        end else if (wr_take && adr_i == {`CTBR_IDX_TIEOFF, 2'b00}) begin
            if (sel_i[0]) tie_ff[7:0] <= dat_i[7:0];
            if (sel_i[1]) tie_ff[8] <= dat_i[8];
        end else if (wr_take && adr_i == {`CTBR_IDX_BIAS, 2'b00}) begin
            if (sel_i[0]) bias_ff[6:0] <= dat_i[6:0];
            if (sel_i[1]) bias_ff[8] <= dat_i[8];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    sequence s_read_of(logic [ADR_W-1:0] a);
        ack_o && !$past(we_i) && $past(adr_i) == a;
    endsequence
    a_ack_single_pulse: assert property (s_take |=> s_answer)
        else $error("ack did not pulse once after a request");
    a_bias_bits_track: assert property (
        {boost_bias_half_o, boost_bias_increase_o, boost_bias_decrease_o}
            == {bias_ff[8], bias_ff[6], bias_ff[5]})
        else $error("bias trim outputs differ from written bits");
    a_tieoff_source_sel: assert property (!$past(rst_i) |->
        tieoff_close_o == $past(tie_want))
        else $error("tie-off switch outputs wrong");
    a_bypass_force_close: assert property (!$past(rst_i) |->
        buffer_bypass_close_o == $past(byp_want))
        else $error("buffer bypass switch wrong");
    a_ground_force_close: assert property (!$past(rst_i) |->
        buffer_ground_close_o == $past(gnd_want))
        else $error("buffer ground switch wrong");
    a_ref_divider_force: assert property (!$past(rst_i) |->
        ref_divider_close_o == $past(ref_want))
        else $error("reference divider switches wrong");
    a_p2p_live_value: assert property (
        s_read_of({`CTBR_IDX_P2P, 2'b00}) |-> dat_o[8:0] == $past(p2p_want))
        else $error("peak-to-peak readout wrong");
    a_peak_live_value: assert property (
        s_read_of({`CTBR_IDX_PEAK, 2'b00}) |-> dat_o[8:0] == $past(peak_want))
        else $error("peak readout wrong");
    a_read_upper_zero: assert property (ack_o |-> dat_o[31:9] == 23'h000000)
        else $error("read data above bit 8 not zero");
endmodule : ctbr_properties
bind ctbr_top ctbr_properties #(.ADR_W(ADR_W), .VAL_W(VAL_W)) u_props (.*);
`default_nettype wire

// >>> dv/tb_codec_tieoff_bias_readout_regs.sv
// self-checking bench for the tie-off/bias register bank
// assumes ctbr_top with default parameters, register header on the include path
`timescale 1ns/1ns
`default_nettype none
`include "ctbr_regs.svh"
module tb_codec_tieoff_bias_readout_regs;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic [11:0] adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [7:0]  auto_tieoff_close_i, tieoff_close_o;
    logic        input_buffer_enabled_i, auto_buffer_bypass_close_i, auto_buffer_ground_close_i;
    logic [2:0]  pwr_mgmt_ref_close_i, ref_divider_close_o;
    logic        buffer_bypass_close_o, buffer_ground_close_o;
    logic        boost_bias_half_o, boost_bias_increase_o, boost_bias_decrease_o;
    logic        alc_left_active_i, alc_right_active_i;
    logic [8:0]  left_peak_to_peak_i, right_peak_to_peak_i, left_peak_i, right_peak_i;
    logic        automute_observe_select_o, speaker_supply_high_i, noise_gate_active_i;
    logic [1:0]  act [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    logic [8:0]  ep2p [4] = '{9'h10f, 9'h0f0, 9'h10f, 9'h0f0};
    logic [8:0]  epk [4] = '{9'h1aa, 9'h1aa, 9'h055, 9'h1aa};
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    ctbr_top dut_u (.*);

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // one classic cycle; a dead slave ends in the bench timeout
    task automatic wb(input logic w, input logic [9:0] idx, input logic [3:0] s,
                      input logic [31:0] d);
        int n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        check("ack wait", n, 32'h2);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        wb(1'b1, idx, 4'h3, d);
    endtask : wr

    task automatic rdchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 4'h3, 32'h0);
        check(nm, rd, exp);
    endtask : rdchk

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 51'h0};
        {auto_tieoff_close_i, input_buffer_enabled_i, pwr_mgmt_ref_close_i} = {8'ha5, 4'h9};
        {auto_buffer_bypass_close_i, auto_buffer_ground_close_i} = 2'b00;
        {alc_left_active_i, alc_right_active_i, speaker_supply_high_i} = 3'h0;
        noise_gate_active_i = 1'b0;
        {left_peak_to_peak_i, right_peak_to_peak_i} = {9'h0f0, 9'h10f};
        {left_peak_i, right_peak_i} = {9'h1aa, 9'h055};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk("tieoff rst", `CTBR_IDX_TIEOFF, 32'h0);
        rdchk("bias rst", `CTBR_IDX_BIAS, 32'h0);
        rdchk("amute rst", `CTBR_IDX_AMUTE, 32'h0);
        rdchk("mask rst", `CTBR_IDX_IRQ_MASK, 32'h0);
        wr(`CTBR_IDX_TIEOFF, 32'h05a);
        check("auto tieoff", tieoff_close_o, 32'ha5);
        // walk one forced-closed switch across every position
        for (int i = 0; i < 8; i++) begin
            wr(`CTBR_IDX_TIEOFF, 32'h100 | (32'h1 << i));
            check("forced tieoff", tieoff_close_o, 32'h1 << i);
        end
        rdchk("tieoff back", `CTBR_IDX_TIEOFF, 32'h180);
        wr(`CTBR_IDX_BIAS, 32'h1ff);
        check("bias trims", {half_inc_dec()}, 32'h7);
        rdchk("bias reserved", `CTBR_IDX_BIAS, 32'h17f);
        wr(`CTBR_IDX_BIAS, 32'h01c);
        check("bias off", {half_inc_dec()}, 32'h0);
        check("bypass on buf", buffer_bypass_close_o, 32'h0);
        check("ground on buf", buffer_ground_close_o, 32'h0);
        check("ref force", ref_divider_close_o, 32'h5);
        input_buffer_enabled_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("bypass off buf", buffer_bypass_close_o, 32'h1);
        check("ground off buf", buffer_ground_close_o, 32'h1);
        wr(`CTBR_IDX_BIAS, 32'h000);
        check("bypass auto", buffer_bypass_close_o, 32'h0);
        check("ref follow", ref_divider_close_o, 32'h1);
        for (int i = 0; i < 4; i++) begin
            {alc_left_active_i, alc_right_active_i} <= act[i];
            @(posedge clk_i);
            rdchk("p2p", `CTBR_IDX_P2P, {23'h0, ep2p[i]});
            rdchk("peak", `CTBR_IDX_PEAK, {23'h0, epk[i]});
        end
        wr(`CTBR_IDX_P2P, 32'h1ff);
        rdchk("p2p ro", `CTBR_IDX_P2P, 32'h0f0);
        wr(`CTBR_IDX_AMUTE, 32'h1ff);
        check("amute sel", automute_observe_select_o, 32'h1);
        rdchk("amute ro", `CTBR_IDX_AMUTE, 32'h020);
        wr(`CTBR_IDX_AMUTE, 32'h000);
        check("amute clr", automute_observe_select_o, 32'h0);
        speaker_supply_high_i <= 1'b1;
        noise_gate_active_i   <= 1'b1;
        repeat (8) @(posedge clk_i);
        rdchk("flags high", `CTBR_IDX_AMUTE, 32'h018);
        check("irq masked", irq_o, 32'h0);
        wr(`CTBR_IDX_IRQ_MASK, 32'h00f);
        check("irq up", irq_o, 32'h1);
        rdchk("stat rise", `CTBR_IDX_IRQ_STAT, 32'h005);
        check("irq cleared", irq_o, 32'h0);
        speaker_supply_high_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check("irq fall", irq_o, 32'h1);
        rdchk("flags mixed", `CTBR_IDX_AMUTE, 32'h008);
        rdchk("stat fall", `CTBR_IDX_IRQ_STAT, 32'h002);
        noise_gate_active_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rdchk("stat gate", `CTBR_IDX_IRQ_STAT, 32'h008);
        wr(10'h07f, 32'h1ff);
        rdchk("unmapped", 10'h07f, 32'h0);
        tally_and_finish();
    end

    function automatic logic [31:0] half_inc_dec();
        return {29'h0, boost_bias_half_o, boost_bias_increase_o, boost_bias_decrease_o};
    endfunction : half_inc_dec
endmodule : tb_codec_tieoff_bias_readout_regs
`default_nettype wire

// >>> rtl/ctbr_pkg.sv
// types shared by the tie-off/bias register bank
// assumes the constants header is included by the modules
package ctbr_pkg;
    typedef logic [8:0] ctbr_word_t;
    typedef logic [3:0] ctbr_evt_t;
    typedef enum logic [2:0] {
        CTBR_SEL_NONE,
        CTBR_SEL_TIEOFF,
        CTBR_SEL_BIAS,
        CTBR_SEL_P2P,
        CTBR_SEL_PEAK,
        CTBR_SEL_AMUTE,
        CTBR_SEL_STAT,
        CTBR_SEL_MASK
    } ctbr_sel_t;
endpackage : ctbr_pkg

// >>> rtl/ctbr_regs.svh
// register indices, field positions and reset values of the tie-off/bias bank
// assumes byte address = 4 * index on a 32-bit classic wishbone bus
`ifndef CTBR_REGS_SVH
`define CTBR_REGS_SVH

`define CTBR_IDX_TIEOFF      10'h04a
`define CTBR_IDX_BIAS        10'h04b
`define CTBR_IDX_P2P         10'h04c
`define CTBR_IDX_PEAK        10'h04d
`define CTBR_IDX_AMUTE       10'h04e
`define CTBR_IDX_IRQ_STAT    10'h050
`define CTBR_IDX_IRQ_MASK    10'h051

`define CTBR_RST_TIEOFF      9'h000
`define CTBR_RST_BIAS        9'h000
`define CTBR_RST_AMUTE_SEL   1'h0
`define CTBR_RST_IRQ         4'h0

// input tie-off register: bit 8 enable, bits 7..0 switch forces
`define CTBR_TIE_EN          8
`define CTBR_TIE_RAUX        7
`define CTBR_TIE_RLIN        6
`define CTBR_TIE_RMINV       5
`define CTBR_TIE_RMNON       4
`define CTBR_TIE_LAUX        3
`define CTBR_TIE_LEFT_LINE_INPUT        2
`define CTBR_TIE_LMINV       1
`define CTBR_TIE_LMNON       0

// bias and buffer register, bit 7 reserved
`define CTBR_BIAS_HALF       8
`define CTBR_BIAS_UP         6
`define CTBR_BIAS_DN         5
`define CTBR_BUF_BYP         4
`define CTBR_BUF_GND         3
`define CTBR_VREF_H          2
`define CTBR_VREF_M          1
`define CTBR_VREF_L          0
`define CTBR_BIAS_WMASK      9'h17f

// automute control and status register
`define CTBR_AM_SEL          5
`define CTBR_AM_HV           4
`define CTBR_AM_GATE         3

// interrupt status bits
`define CTBR_EV_HV_RISE      0
`define CTBR_EV_HV_FALL      1
`define CTBR_EV_GATE_HOLD    2
`define CTBR_EV_GATE_OPEN    3

`endif

// >>> rtl/ctbr_sync.sv
// three-stage synchroniser with agreement filter for asynchronous levels
// assumes inputs come from outside the clk_i domain
`timescale 1ns/1ns
`default_nettype none
module ctbr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync2_ff;
    logic [WIDTH-1:0] sync3_ff;
    logic [WIDTH-1:0] level_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff  <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            meta_ff  <= async_i;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a bit only moves once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_ff <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    level_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    assign level_o = level_ff;
endmodule : ctbr_sync
`default_nettype wire

// >>> rtl/ctbr_top.sv
// tie-off override, bias trim and level readout register bank, wishbone slave
// assumes a classic wishbone master on clk_i; alc values and auto switch
// requests come from logic on clk_i; detector flags arrive asynchronously
//
// Behaviour
// RQ1: the override enable picks manual force bits or automatic control for all input tie-offs.
// RQ2: with override on, each right-channel force bit opens its switch at 0 and closes it at 1.
// RQ3: with override on, each left-channel force bit opens its switch at 0 and closes it at 1.
// RQ4: a half-bias bit drives the mix/boost stages to half bias current when set.
// RQ5: a bias-increase bit raises the mix/boost bias by 500 microamps when set.
// RQ6: a bias-decrease bit lowers the mix/boost bias by 250 microamps when set.
// RQ7: the bypass force bit closes the buffer bypass switch while the buffer is off, else auto.
// RQ8: the ground force bit closes the buffer output ground switch while the buffer is off.
// RQ9: each of three divider force bits closes its switch at 1 and follows power management at 0.
// RQ10: a read-only register returns the live peak-to-peak detector value on every read.
// RQ11: a second read-only register returns the live peak detector value.
// RQ12: with both channels under level control each readout gives the larger channel value.
// RQ13: the automute select bit observes attenuator input at 0 and serial playback input at 1.
// RQ14: a read-only bit shows the speaker supply high-voltage detector state.
// RQ15: a read-only bit shows 1 while the noise gate holds gain and 0 while gain may change.
// RQ16: the tie-off and the bias/buffer registers reset to zero.
// RQ17: reserved bits read zero, writes to them and to read-only fields have no effect.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ctbr_regs.svh"
module ctbr_top #(
    parameter int ADR_W = 12,
    parameter int VAL_W = 9
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,

    // wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    output logic                  irq_o,

    // automatic tie-off requests, bit order as the force fields
    input  wire logic [7:0]       auto_tieoff_close_i,
    output logic      [7:0]       tieoff_close_o,

    // input buffer and reference divider
    input  wire logic             input_buffer_enabled_i,
    input  wire logic             auto_buffer_bypass_close_i,
    input  wire logic             auto_buffer_ground_close_i,
    input  wire logic [2:0]       pwr_mgmt_ref_close_i,
    output logic                  buffer_bypass_close_o,
    output logic                  buffer_ground_close_o,
    output logic      [2:0]       ref_divider_close_o,

    // bias trims
    output logic                  boost_bias_half_o,
    output logic                  boost_bias_increase_o,
    output logic                  boost_bias_decrease_o,

    // level detectors
    input  wire logic             alc_left_active_i,
    input  wire logic             alc_right_active_i,
    input  wire logic [VAL_W-1:0] left_peak_to_peak_i,
    input  wire logic [VAL_W-1:0] right_peak_to_peak_i,
    input  wire logic [VAL_W-1:0] left_peak_i,
    input  wire logic [VAL_W-1:0] right_peak_i,

    // automute and status
    output logic                  automute_observe_select_o,
    input  wire logic             speaker_supply_high_i,
    input  wire logic             noise_gate_active_i
);
    ctbr_pkg::ctbr_word_t tieoff_ff;
    ctbr_pkg::ctbr_word_t bias_ff;
    logic                 amute_sel_ff;
    ctbr_pkg::ctbr_evt_t  irq_stat_ff;
    ctbr_pkg::ctbr_evt_t  irq_mask_ff;

    ctbr_pkg::ctbr_evt_t  nxt_irq_stat;
    ctbr_pkg::ctbr_evt_t  events;

    logic                 ack_ff;
    logic [31:0]          dat_ff;

    logic [7:0]           tieoff_close_ff;
    logic                 bypass_ff;
    logic                 ground_ff;
    logic [2:0]           ref_close_ff;

    logic [1:0]           flags_sync;
    logic                 hv_prev_ff;
    logic                 gate_prev_ff;
    logic [VAL_W-1:0]     p2p_sel;
    logic [VAL_W-1:0]     peak_sel;

    ctbr_pkg::ctbr_sel_t  reg_sel;
    ctbr_pkg::ctbr_word_t rd_word;
    logic                 req;
    logic                 wr_lo;
    logic                 wr_hi;

    // detector flags come from analog comparators
    ctbr_sync #(
        .WIDTH (2)
    ) u_flag_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({noise_gate_active_i, speaker_supply_high_i}),
        .level_o (flags_sync)
    );

    // one new request per handshake; ack drops the cycle after it rose
    assign req   = cyc_i & stb_i & ~ack_ff;
    assign wr_lo = req & we_i & sel_i[0];
    assign wr_hi = req & we_i & sel_i[1];

    always_comb begin
        if (adr_i[1:0] != 2'h0) begin
            reg_sel = ctbr_pkg::CTBR_SEL_NONE;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_TIEOFF) begin
            reg_sel = ctbr_pkg::CTBR_SEL_TIEOFF;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_BIAS) begin
            reg_sel = ctbr_pkg::CTBR_SEL_BIAS;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_P2P) begin
            reg_sel = ctbr_pkg::CTBR_SEL_P2P;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_PEAK) begin
            reg_sel = ctbr_pkg::CTBR_SEL_PEAK;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_AMUTE) begin
            reg_sel = ctbr_pkg::CTBR_SEL_AMUTE;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_IRQ_STAT) begin
            reg_sel = ctbr_pkg::CTBR_SEL_STAT;
        end else if (adr_i[ADR_W-1:2] == `CTBR_IDX_IRQ_MASK) begin
            reg_sel = ctbr_pkg::CTBR_SEL_MASK;
        end else begin
            reg_sel = ctbr_pkg::CTBR_SEL_NONE;
        end
    end

    // registered ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    // tie-off register, byte lane 0 holds forces, lane 1 the enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tieoff_ff <= `CTBR_RST_TIEOFF; // [RQ16]
        end else if (reg_sel == ctbr_pkg::CTBR_SEL_TIEOFF) begin
            if (wr_lo) begin
                tieoff_ff[7:0] <= dat_i[7:0];
            end
            if (wr_hi) begin
                tieoff_ff[8] <= dat_i[8];
            end
        end
    end

    // bias and buffer register, reserved bit 7 never stores
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bias_ff <= `CTBR_RST_BIAS; // [RQ16]
        end else if (reg_sel == ctbr_pkg::CTBR_SEL_BIAS) begin
            if (wr_lo) begin
                bias_ff[7:0] <= dat_i[7:0] & 8'(`CTBR_BIAS_WMASK); // [RQ17]
            end
            if (wr_hi) begin
                bias_ff[8] <= dat_i[8];
            end
        end
    end

    // only the select bit of the automute register is writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amute_sel_ff <= `CTBR_RST_AMUTE_SEL;
        end else if (wr_lo && reg_sel == ctbr_pkg::CTBR_SEL_AMUTE) begin
            amute_sel_ff <= dat_i[`CTBR_AM_SEL]; // [RQ13] [RQ17]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= `CTBR_RST_IRQ;
        end else if (wr_lo && reg_sel == ctbr_pkg::CTBR_SEL_MASK) begin
            irq_mask_ff <= dat_i[3:0];
        end
    end

    // tie-off switch drive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tieoff_close_ff <= 8'h00;
        end else if (tieoff_ff[`CTBR_TIE_EN]) begin
            // right half then left half of the force byte
            tieoff_close_ff[7:4] <= tieoff_ff[7:4]; // [RQ1] [RQ2]
            tieoff_close_ff[3:0] <= tieoff_ff[3:0]; // [RQ1] [RQ3]
        end else begin
            tieoff_close_ff <= auto_tieoff_close_i; // [RQ1]
        end
    end

    // forced closure only applies while the buffer amp is off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bypass_ff <= 1'b0;
            ground_ff <= 1'b0;
        end else begin
            if (bias_ff[`CTBR_BUF_BYP] && !input_buffer_enabled_i) begin
                bypass_ff <= 1'b1; // [RQ7]
            end else begin
                bypass_ff <= auto_buffer_bypass_close_i; // [RQ7]
            end
            if (bias_ff[`CTBR_BUF_GND] && !input_buffer_enabled_i) begin
                ground_ff <= 1'b1; // [RQ8]
            end else begin
                ground_ff <= auto_buffer_ground_close_i; // [RQ8]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_close_ff <= 3'h0;
        end else begin
            ref_close_ff <= bias_ff[2:0] | pwr_mgmt_ref_close_i; // [RQ9]
        end
    end

    assign tieoff_close_o            = tieoff_close_ff;
    assign buffer_bypass_close_o     = bypass_ff;
    assign buffer_ground_close_o     = ground_ff;
    assign ref_divider_close_o       = ref_close_ff;
    assign boost_bias_half_o         = bias_ff[`CTBR_BIAS_HALF]; // [RQ4]
    assign boost_bias_increase_o     = bias_ff[`CTBR_BIAS_UP]; // [RQ5]
    assign boost_bias_decrease_o     = bias_ff[`CTBR_BIAS_DN]; // [RQ6]
    assign automute_observe_select_o = amute_sel_ff; // [RQ13]

    // readout channel choice; a lone active channel reports itself
    always_comb begin
        if (alc_left_active_i && alc_right_active_i) begin
            p2p_sel  = (left_peak_to_peak_i > right_peak_to_peak_i) ?
                       left_peak_to_peak_i : right_peak_to_peak_i; // [RQ12]
            peak_sel = (left_peak_i > right_peak_i) ?
                       left_peak_i : right_peak_i; // [RQ12]
        end else if (alc_right_active_i) begin
            p2p_sel  = right_peak_to_peak_i;
            peak_sel = right_peak_i;
        end else begin
            p2p_sel  = left_peak_to_peak_i;
            peak_sel = left_peak_i;
        end
    end

    // status events from the filtered detector levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_prev_ff   <= 1'b0;
            gate_prev_ff <= 1'b0;
        end else begin
            hv_prev_ff   <= flags_sync[0];
            gate_prev_ff <= flags_sync[1];
        end
    end

    always_comb begin
        events                     = 4'h0;
        events[`CTBR_EV_HV_RISE]   = flags_sync[0] & ~hv_prev_ff;
        events[`CTBR_EV_HV_FALL]   = ~flags_sync[0] & hv_prev_ff;
        events[`CTBR_EV_GATE_HOLD] = flags_sync[1] & ~gate_prev_ff;
        events[`CTBR_EV_GATE_OPEN] = ~flags_sync[1] & gate_prev_ff;
    end

    // read clears the sticky bits, but an event in that cycle survives
    always_comb begin
        nxt_irq_stat = irq_stat_ff | events;
        if (req && !we_i && reg_sel == ctbr_pkg::CTBR_SEL_STAT) begin
            nxt_irq_stat = events;
        end
    end

    // sticky status bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= `CTBR_RST_IRQ;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_word = 9'h000;
        case (reg_sel)
            ctbr_pkg::CTBR_SEL_TIEOFF: begin
                rd_word = tieoff_ff;
            end
            ctbr_pkg::CTBR_SEL_BIAS: begin
                rd_word = bias_ff;
            end
            ctbr_pkg::CTBR_SEL_P2P: begin
                rd_word = p2p_sel; // [RQ10]
            end
            ctbr_pkg::CTBR_SEL_PEAK: begin
                rd_word = peak_sel; // [RQ11]
            end
            ctbr_pkg::CTBR_SEL_AMUTE: begin
                rd_word[`CTBR_AM_SEL]  = amute_sel_ff;
                rd_word[`CTBR_AM_HV]   = flags_sync[0]; // [RQ14]
                rd_word[`CTBR_AM_GATE] = flags_sync[1]; // [RQ15]
            end
            ctbr_pkg::CTBR_SEL_STAT: begin
                rd_word[3:0] = irq_stat_ff;
            end
            ctbr_pkg::CTBR_SEL_MASK: begin
                rd_word[3:0] = irq_mask_ff;
            end
            default: begin
                rd_word = 9'h000;
            end
        endcase
    end

    // read data captured on the request edge, held while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_ff <= {23'h00_0000, rd_word}; // [RQ17]
        end else if (req) begin
            dat_ff <= 32'h0000_0000;
        end
    end

    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
endmodule : ctbr_top
`default_nettype wire
